/* File: exc_pkg.sv */
// constants for the exception and link stack unit
package exc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int STATUS_W = 16;
  localparam int TRACE_BIT = 15;
  localparam int OP_W = 8;
  // protected write ranges, octal bounds written in hex
  localparam logic [15:0] PROLOGUE_LO = 16'h0000;
  localparam logic [15:0] PROLOGUE_HI = 16'h00ff;
  localparam logic [15:0] DBASE_LO = 16'h3800;
  localparam logic [15:0] DBASE_HI = 16'h3fff;
  localparam logic [15:0] NORAM_LO = 16'h4000;
  localparam logic [15:0] NORAM_HI = 16'hefff;
  localparam logic [15:0] PROM_LO = 16'hf000;
  localparam logic [15:0] PROM_HI = 16'hffff;
  // link stack placement
  localparam int LINK_DEPTH = 32;
  localparam int LINK_PTR_W = 6;
  localparam logic [15:0] LINK_BASE = 16'h3fc0;
  localparam logic [15:0] LINK_TOP = 16'h3fff;
  localparam int LINK_WORDS = 64;
  // register set level bounds
  localparam logic [3:0] LEVEL_MAX = 4'h7;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  // refresh timer, in microseconds and cycles
  localparam int CLK_MHZ = 40;
  localparam int REFRESH_US = 1800;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int TIMER_MULT = 3;
  // exception cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam int CAUSE_ILL_INSTR = 0;
  localparam int CAUSE_ILL_ADDR = 1;
  localparam int CAUSE_STACK = 2;
  localparam logic [15:0] STATUS_RST = 16'h0000;
endpackage

/* File: exc_unit.sv */
// exception, trace, interval timer and link stack unit
`timescale 1ns/10ps
module exc_unit #(
  parameter int REFRESH_CYCLES = exc_pkg::REFRESH_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic FETCH_I,
  input wire logic [exc_pkg::OP_W-1:0] OPCODE_I,
  input wire logic OP_VALID_I,
  input wire logic PRIV_I,
  input wire logic [exc_pkg::STATUS_W-1:0] STATUS_I,
  input wire logic MEM_WR_I,
  input wire logic MEM_RD_I,
  input wire logic [exc_pkg::ADDR_W-1:0] MEM_ADDR_I,
  input wire logic LEVEL_UP_I,
  input wire logic LEVEL_DN_I,
  input wire logic CALL_I,
  input wire logic RETURN_I,
  input wire logic RESUME_I,
  input wire logic [exc_pkg::ADDR_W-1:0] RET_ADDR_I,
  input wire logic CAUSE_CLR_I,
  output logic MEM_WR_O,
  output logic TRACE_IRQ_O,
  output logic TIMER_IRQ_O,
  output logic EXC_IRQ_O,
  output logic [2:0] CAUSE_O,
  output logic [3:0] LEVEL_O,
  output logic RET_VALID_O,
  output logic [exc_pkg::ADDR_W-1:0] RET_ADDR_O,
  output logic [exc_pkg::STATUS_W-1:0] RET_STATUS_O,
  output logic [exc_pkg::LINK_PTR_W-1:0] LINK_CNT_O
);
  import exc_pkg::*;

  // legal opcodes: 0x00-0xef; privileged: memory write and autocorrelate
  localparam logic [7:0] OP_LAST = 8'hef;
  localparam logic [7:0] MEM_WRITE_OP = 8'h30;
  localparam logic [7:0] AUTOCORRELATE_OP = 8'h31;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_protected(input logic [15:0] a);
    is_protected = in_range(a, PROLOGUE_LO, PROLOGUE_HI) || in_range(a, DBASE_LO, DBASE_HI)
                   || in_range(a, NORAM_LO, NORAM_HI) || in_range(a, PROM_LO, PROM_HI);
  endfunction

  logic ill_instr, ill_addr, lvl_ovf, lnk_ovf;
  logic trace_d, trace_q, tmr_irq_d, tmr_irq_q, exc_d, exc_q, wr_d, wr_q;
  logic [2:0] cause_d, cause_q;
  logic [3:0] level_d, level_q;
  logic [31:0] tcnt_d, tcnt_q;
  logic [1:0] mult_d, mult_q;
  logic [ADDR_W-1:0] stk_addr [LINK_DEPTH];
  logic [STATUS_W-1:0] stk_status [LINK_DEPTH];
  logic [LINK_PTR_W-1:0] sp_d, sp_q;
  logic rv_d, rv_q;
  logic [ADDR_W-1:0] ra_d, ra_q;
  logic [STATUS_W-1:0] rp_d, rp_q;
  logic push, pop, disc;
  logic [LINK_PTR_W-1:0] keep;

  // exception detection
  always_comb begin
    ill_instr = OP_VALID_I && ((OPCODE_I > OP_LAST) || (!PRIV_I &&
                (OPCODE_I == MEM_WRITE_OP || OPCODE_I == AUTOCORRELATE_OP)));
    // only writes are checked, reads pass freely
    ill_addr = MEM_WR_I && !PRIV_I && is_protected(MEM_ADDR_I);
    lvl_ovf = (LEVEL_UP_I && level_q == LEVEL_MAX)
              || (LEVEL_DN_I && level_q == LEVEL_RST);
    lnk_ovf = (CALL_I && sp_q == LINK_PTR_W'(LINK_DEPTH))
              || (RETURN_I && !CALL_I && sp_q == '0);
  end

  // exception, trace, write gate and cause state
  always_comb begin
    trace_d = FETCH_I && STATUS_I[TRACE_BIT];
    wr_d = MEM_WR_I && !ill_addr;
    exc_d = ill_instr || ill_addr || lvl_ovf || lnk_ovf;
    cause_d = cause_q;
    if (CAUSE_CLR_I) begin
      cause_d = CAUSE_NONE;
    end
    // set wins over clear
    cause_d[CAUSE_ILL_INSTR] = cause_d[CAUSE_ILL_INSTR] | ill_instr;
    cause_d[CAUSE_ILL_ADDR] = cause_d[CAUSE_ILL_ADDR] | ill_addr;
    cause_d[CAUSE_STACK] = cause_d[CAUSE_STACK] | lvl_ovf | lnk_ovf;
    level_d = level_q;
    if (LEVEL_UP_I && !LEVEL_DN_I && level_q != LEVEL_MAX) begin
      level_d = level_q + 4'h1;
    end else if (LEVEL_DN_I && !LEVEL_UP_I && level_q != LEVEL_RST) begin
      level_d = level_q - 4'h1;
    end
  end

  // interval timer: several refresh periods per tick
  always_comb begin
    tcnt_d = tcnt_q + 32'h1;
    mult_d = mult_q;
    tmr_irq_d = 1'b0;
    if (tcnt_q == 32'(REFRESH_CYCLES - 1)) begin
      tcnt_d = '0;
      mult_d = mult_q + 2'h1;
      if (mult_q == 2'(TIMER_MULT - 1)) begin
        mult_d = '0;
        tmr_irq_d = 1'b1;
      end
    end
  end

  // link stack control; entries model the words at 37700-37777
  always_comb begin
    push = CALL_I && !lnk_ovf;
    pop = RETURN_I && !lnk_ovf && !CALL_I;
    disc = RESUME_I && !CALL_I && !RETURN_I;
    sp_d = sp_q;
    rv_d = 1'b0;
    ra_d = ra_q;
    rp_d = rp_q;
    keep = '0;
    if (disc) begin
      // keep up to the highest entry with another status word
      for (int i = 0; i < LINK_DEPTH; i++) begin
        if (LINK_PTR_W'(i) < sp_q && stk_status[i] != STATUS_I) begin
          keep = LINK_PTR_W'(i + 1);
        end
      end
    end
    if (push) begin
      sp_d = sp_q + 6'h1;
    end else if (pop) begin
      sp_d = sp_q - 6'h1;
      rv_d = 1'b1;
      ra_d = stk_addr[5'(sp_q - 6'h1)];
      rp_d = stk_status[5'(sp_q - 6'h1)];
    end else if (disc) begin
      sp_d = keep;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (push) begin
      stk_addr[sp_q[4:0]] <= RET_ADDR_I;
      stk_status[sp_q[4:0]] <= STATUS_I;
    end
  end

  // state registers
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      trace_q <= 1'b0;
      tmr_irq_q <= 1'b0;
      exc_q <= 1'b0;
      wr_q <= 1'b0;
      cause_q <= CAUSE_NONE;
      level_q <= LEVEL_RST;
      tcnt_q <= '0;
      mult_q <= '0;
      sp_q <= '0;
      rv_q <= 1'b0;
      ra_q <= '0;
      rp_q <= STATUS_RST;
    end else begin
      trace_q <= trace_d;
      tmr_irq_q <= tmr_irq_d;
      exc_q <= exc_d;
      wr_q <= wr_d;
      cause_q <= cause_d;
      level_q <= level_d;
      tcnt_q <= tcnt_d;
      mult_q <= mult_d;
      sp_q <= sp_d;
      rv_q <= rv_d;
      ra_q <= ra_d;
      rp_q <= rp_d;
    end
  end

  assign TRACE_IRQ_O = trace_q;
  assign TIMER_IRQ_O = tmr_irq_q;
  assign EXC_IRQ_O = exc_q;
  assign MEM_WR_O = wr_q;
  assign CAUSE_O = cause_q;
  assign LEVEL_O = level_q;
  assign RET_VALID_O = rv_q;
  assign RET_ADDR_O = ra_q;
  assign RET_STATUS_O = rp_q;
  assign LINK_CNT_O = sp_q;

  // checks
  a_trace_fetch: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    FETCH_I && STATUS_I[TRACE_BIT] |=> TRACE_IRQ_O) else $error("trace missed");
  a_exc_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    ill_addr |=> EXC_IRQ_O && CAUSE_O[CAUSE_ILL_ADDR]) else $error("addr exc missed");
  a_write_block: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    ill_addr |=> !MEM_WR_O) else $error("protected write passed");
  a_read_free: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    MEM_RD_I && !MEM_WR_I && !OP_VALID_I && !LEVEL_UP_I && !LEVEL_DN_I && !CALL_I
    && !RETURN_I |=> !EXC_IRQ_O) else $error("read raised exception");
  a_instr_priv: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    OP_VALID_I && !PRIV_I && OPCODE_I == MEM_WRITE_OP |=> CAUSE_O[CAUSE_ILL_INSTR])
    else $error("privileged op passed");
  a_level_bound: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    LEVEL_O <= LEVEL_MAX) else $error("level out of range");
  a_level_ovf: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    LEVEL_UP_I && !LEVEL_DN_I && LEVEL_O == LEVEL_MAX
    |=> EXC_IRQ_O && CAUSE_O[CAUSE_STACK] && $stable(LEVEL_O))
    else $error("level overflow missed");
  a_stack_under: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    RETURN_I && !CALL_I && LINK_CNT_O == '0 |=> CAUSE_O[CAUSE_STACK] && !RET_VALID_O)
    else $error("underflow missed");
  a_call_return: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CALL_I && !lnk_ovf ##1 RETURN_I && !CALL_I |=> RET_VALID_O
    && RET_ADDR_O == $past(RET_ADDR_I, 2)) else $error("return address wrong");
  a_link_guard: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    MEM_WR_I && !PRIV_I && MEM_ADDR_I >= LINK_BASE && MEM_ADDR_I <= LINK_TOP
    |=> EXC_IRQ_O && !MEM_WR_O) else $error("link stack write passed");
  a_cause_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CAUSE_O[CAUSE_STACK] && !CAUSE_CLR_I |=> CAUSE_O[CAUSE_STACK])
    else $error("cause lost");
  c_timer: cover property (@(posedge CORE_CLK_I) disable iff (!RSTN_I) TIMER_IRQ_O);
  c_resume: cover property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    disc && sp_q != '0 ##1 sp_q == '0);
  c_ret: cover property (@(posedge CORE_CLK_I) disable iff (!RSTN_I) RET_VALID_O);
endmodule

/* File: mem_model.sv */
// memory path model that counts the gated writes reaching memory
`timescale 1ns/10ps
module mem_model (
  input wire logic clk_i,
  input wire logic wr_i,
  output int wr_cnt_o
);
  // only a strobe from the unit reaches memory, so blocked writes never land
  initial wr_cnt_o = 0;
  always @(posedge clk_i) begin
    if (wr_i === 1'b1) wr_cnt_o <= wr_cnt_o + 1;
  end
endmodule

/* File: tb_exception_and_link_stack_unit.sv */
// self-checking testbench for the exception and link stack unit
`timescale 1ns/10ps
module tb_exception_and_link_stack_unit;
  import exc_pkg::*;
  logic clk = 0, rstn = 0, fetch = 0, opv = 0, priv = 0, wr = 0, rd = 0;
  logic up = 0, dn = 0, call = 0, ret = 0, res = 0, cclr = 0;
  logic [7:0] opc = 8'h00;
  logic [15:0] sw = 16'h0000, addr = 16'h0000, raddr = 16'h0000;
  logic mwr, trq, tmi, exi, rv;
  logic [2:0] cause;
  logic [3:0] lvl;
  logic [15:0] ra, rp;
  logic [5:0] cnt;
  int err_total = 0, cmp_count = 0, wrs, tpul = 0;
  logic [15:0] pa [9] = '{16'h0000, 16'h00ff, 16'h3800, 16'h3fc0, 16'h3fff,
    16'h4000, 16'hefff, 16'hf000, 16'hffff};
  always #12.5 clk = ~clk;
  // short refresh count keeps the timer period at 12 cycles
  exc_unit #(.REFRESH_CYCLES(4)) i_exc_unit (.CORE_CLK_I(clk), .RSTN_I(rstn),
    .FETCH_I(fetch), .OPCODE_I(opc), .OP_VALID_I(opv), .PRIV_I(priv), .STATUS_I(sw),
    .MEM_WR_I(wr), .MEM_RD_I(rd), .MEM_ADDR_I(addr), .LEVEL_UP_I(up), .LEVEL_DN_I(dn),
    .CALL_I(call), .RETURN_I(ret), .RESUME_I(res), .RET_ADDR_I(raddr),
    .CAUSE_CLR_I(cclr), .MEM_WR_O(mwr), .TRACE_IRQ_O(trq), .TIMER_IRQ_O(tmi),
    .EXC_IRQ_O(exi), .CAUSE_O(cause), .LEVEL_O(lvl), .RET_VALID_O(rv),
    .RET_ADDR_O(ra), .RET_STATUS_O(rp), .LINK_CNT_O(cnt));
  mem_model i_mem_model (.clk_i(clk), .wr_i(mwr), .wr_cnt_o(wrs));
  // timer pulse counter
  always @(posedge clk) if (tmi === 1'b1) tpul <= tpul + 1;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one edge that takes the pulses, then drop them and let outputs settle
  task automatic cyc;
    @(posedge clk);
    {fetch, opv, wr, rd, up, dn, call, ret, res, cclr} <= '0;
    #1;
  endtask
  task automatic clr;
    @(posedge clk) cclr <= 1;
    cyc;
    chk("cause cleared", 16'h0, 16'(cause));
  endtask
  task automatic op(input logic [7:0] o, input logic p, input logic e);
    @(posedge clk) begin opc <= o; priv <= p; opv <= 1; end
    cyc;
    chk("op exc", 16'(e), 16'(exi));
    repeat (3) @(posedge clk);
    chk("op cause", 16'(e) << CAUSE_ILL_INSTR, 16'(cause));
    clr;
  endtask
  task automatic mw(input logic [15:0] a, input logic w, input logic e);
    int n;
    n = wrs;
    @(posedge clk) begin addr <= a; priv <= 0; wr <= w; rd <= !w; end
    cyc;
    chk("addr exc", 16'(e), 16'(exi));
    chk("write gate", 16'(w && !e), 16'(mwr));
    chk("addr cause", 16'(e) << CAUSE_ILL_ADDR, 16'(cause));
    cyc;
    chk("mem writes", 16'(n + (w && !e)), 16'(wrs));
    clr;
  endtask
  task automatic lk(input logic [2:0] k, input logic [15:0] p, input logic [15:0] a);
    @(posedge clk) begin {call, ret, res} <= k; sw <= p; raddr <= a; end
    cyc;
  endtask
  task automatic t_trace_timer;
    int n0;
    @(posedge clk) begin sw <= 16'h8000; fetch <= 1; end
    cyc;
    chk("trace", 16'h1, 16'(trq));
    @(posedge clk) begin sw <= 16'h0000; fetch <= 1; end
    cyc;
    chk("trace off", 16'h0, 16'(trq));
    n0 = tpul;
    repeat (48) @(posedge clk);
    #1;
    chk("timer pulses", 16'h4, 16'(tpul - n0));
  endtask
  task automatic t_level;
    for (int d = 0; d < 2; d++) begin
      repeat (7) begin
        @(posedge clk) begin up <= !d; dn <= d; end
        cyc;
      end
      chk("level", d ? 16'h0 : 16'h7, 16'(lvl));
      @(posedge clk) begin up <= !d; dn <= d; end
      cyc;
      chk("level exc", 16'h1, 16'(exi));
      chk("level held", d ? 16'h0 : 16'h7, 16'(lvl));
      chk("level cause", 16'h1 << CAUSE_STACK, 16'(cause));
      clr;
    end
  endtask
  task automatic t_stack;
    // call, then return on the very next edge
    @(posedge clk) begin call <= 1; sw <= 16'h0004; raddr <= 16'h6666; end
    @(posedge clk) begin call <= 0; ret <= 1; end
    cyc;
    chk("b2b ret valid", 16'h1, 16'(rv));
    chk("b2b ret addr", 16'h6666, ra);
    chk("b2b ret status", 16'h0004, rp);
    chk("b2b count", 16'h0, 16'(cnt));
    lk(3'b100, 16'h0001, 16'h1111);
    lk(3'b100, 16'h0002, 16'h2222);
    lk(3'b100, 16'h0002, 16'h3333);
    chk("push count", 16'h3, 16'(cnt));
    lk(3'b001, 16'h0002, 16'h0000);
    chk("resume drop", 16'h1, 16'(cnt));
    lk(3'b010, 16'h0002, 16'h0000);
    chk("ret valid", 16'h1, 16'(rv));
    chk("ret addr", 16'h1111, ra);
    chk("ret status", 16'h0001, rp);
    chk("pop count", 16'h0, 16'(cnt));
    lk(3'b010, 16'h0002, 16'h0000);
    chk("underflow", 16'h1, 16'(exi));
    chk("underflow cause", 16'h1 << CAUSE_STACK, 16'(cause));
    clr;
    repeat (LINK_DEPTH) lk(3'b100, 16'h0003, 16'h4444);
    chk("full count", 16'(LINK_DEPTH), 16'(cnt));
    lk(3'b100, 16'h0003, 16'h5555);
    chk("overflow", 16'h1, 16'(exi));
    chk("overflow held", 16'(LINK_DEPTH), 16'(cnt));
    clr;
    lk(3'b001, 16'h0003, 16'h0000);
    chk("resume all", 16'h0, 16'(cnt));
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    cyc;
    chk("reset level", 16'h0, 16'(lvl));
    chk("reset count", 16'h0, 16'(cnt));
    t_trace_timer;
    op(8'hf0, 0, 1);
    op(8'hf0, 1, 1);
    op(8'h30, 0, 1);
    op(8'h31, 0, 1);
    op(8'h31, 1, 0);
    op(8'h10, 0, 0);
    foreach (pa[i]) mw(pa[i], 1, 1);
    mw(16'h3fc0, 0, 0);
    mw(16'h0100, 1, 0);
    mw(16'h37ff, 1, 0);
    t_level;
    t_stack;
    finish_test;
  end
  // watchdog against a hang
  initial begin
    #(25 * 20000);
    err_total++;
    finish_test;
  end
endmodule
